// File: rtl/mdr_defs.svh
// constants for the dual-port memory block
`ifndef MDR_DEFS_SVH
`define MDR_DEFS_SVH
`define MDR_DW         72
`define MDR_AW         16
`define MDR_BEW        8
`define MDR_IW         13
`define MDR_DEPTH      8192
`define MDR_LANE9      9
`define MDR_LANE8      8
`define MDR_CTRL_OFF   12'h000
`define MDR_STAT_OFF   12'h004
`define MDR_WCNT_OFF   12'h008
`define MDR_CTRL_W     7
`define MDR_CTRL_RST   7'h00
`define MDR_B_IO       0
`define MDR_B_SIMPLE   1
`define MDR_B_INSEL    2
`define MDR_B_BYPA     3
`define MDR_B_BYPB     4
`define MDR_B_NARROW   5
`define MDR_B_BEFORCE  6
`define MDR_WCNT_W     16
`define MDR_WCNT_ONE   16'h0001
`define MDR_BE_ALL     8'hff
`endif

// File: rtl/mdr_pkg.sv
// types for the dual-port memory block
package mdr_pkg;
	typedef enum logic [1:0] {
		MDR_IDLE = 2'b01,
		MDR_ACK  = 2'b10
	} mdr_apb_state_type;
	typedef logic [71:0] mdr_word_type;
endpackage

// File: rtl/mdr_port.sv
// input and output register stage of one memory port
`timescale 1ns/100ps
`default_nettype none
`include "mdr_defs.svh"
module mdr_port
	import mdr_pkg::*;
(
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 in_tick,
	input  wire logic                 out_tick,
	input  wire logic                 in_en,
	input  wire logic                 out_en,
	input  wire logic                 in_clr,
	input  wire logic                 out_clr,
	input  wire logic                 we_keep,
	input  wire logic [`MDR_AW-1:0]   addr,
	input  wire logic [`MDR_BEW-1:0]  be,
	input  wire logic                 renwe,
	input  wire mdr_word_type         wdata,
	input  wire mdr_word_type         raw,
	output logic [`MDR_AW-1:0]        addr_q,
	output logic [`MDR_BEW-1:0]       be_q,
	output logic                      we_q,
	output mdr_word_type              wdata_q,
	output logic                      acc_q,
	output mdr_word_type              out_q
);
	// input registers share one clock tick
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			addr_q  <= '0;
			be_q    <= '0;
			wdata_q <= '0;
			acc_q   <= 1'b0;
		end
		else if (in_clr)
		begin
			addr_q  <= '0; // [R09] [R13]
			be_q    <= '0;
			wdata_q <= '0;
			acc_q   <= 1'b0;
		end
		else
		begin
			acc_q <= in_tick && in_en; // [R03] [R18]
			if (in_tick && in_en)
			begin
				addr_q  <= addr; // [R03] [R06]
				be_q    <= be;
				wdata_q <= wdata;
			end
		end
	end

	// renwe register; may be exempt from clear when used as read enable
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			we_q <= 1'b0;
		else if (in_clr && !we_keep)
			we_q <= 1'b0; // [R10] [R14]
		else if (in_tick && in_en)
			we_q <= renwe; // [R15]
	end

	// data output register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			out_q <= '0;
		else if (out_clr)
			out_q <= '0; // [R13]
		else if (out_tick && out_en)
			out_q <= raw; // [R12] [R18]
	end
endmodule
`default_nettype wire

// File: rtl/mdr_top.sv
// dual-port 72-bit memory with selectable clocking and apb control
// Functional notes
// (R01) write only lanes whose byte enable is set
// (R02) 8-bit lanes in widths without parity
// (R03) all input registers share one chosen clock
// (R04) output register may be used or bypassed
// (R05) 72-bit write and read data per port
// (R06) each port: address, enables, renwe, clock
// (R07) independent clock mode for true dual-port
// (R08) port registers follow their own port clock
// (R09) per-port clock enable and clear
// (R10) every register clearable in true dual-port
// (R11) input/output clock mode in both port modes
// (R12) inputs and outputs on different clocks
// (R13) input and output sides own enable, clear
// (R14) simple mode read enable has no clear; here only in input/output clock mode, clr_b clears it otherwise
// (R15) one renwe selects read or write
// (R16) byte enables may be forced high
// (R17) memory contents are never initialised
// (R18) deasserted enable holds registers, no write
// (R19) user keeps address stable to clock
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "mdr_defs.svh"
module mdr_top
	import mdr_pkg::*;
(
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic [31:0]               prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 clk_a,
	input  wire logic                 clken_a,
	input  wire logic                 clr_a,
	input  wire logic [`MDR_AW-1:0]   addr_a,
	input  wire logic [`MDR_BEW-1:0]  be_a,
	input  wire logic                 renwe_a,
	input  wire mdr_word_type         wdata_a,
	output mdr_word_type              rdata_a,
	input  wire logic                 clk_b,
	input  wire logic                 clken_b,
	input  wire logic                 clr_b,
	input  wire logic [`MDR_AW-1:0]   addr_b,
	input  wire logic [`MDR_BEW-1:0]  be_b,
	input  wire logic                 renwe_b,
	input  wire mdr_word_type         wdata_b,
	output mdr_word_type              rdata_b
);
	logic [`MDR_CTRL_W-1:0]  ctrl_r;
	logic [`MDR_WCNT_W-1:0]  wcnt_r;
	mdr_apb_state_type       apb_r;
	logic                    clka_d_r;
	logic                    clkb_d_r;
	logic                    tick_a;
	logic                    tick_b;
	logic                    io_mode;
	logic                    simple;
	logic                    in_sel;
	logic                    in_tick;
	logic                    out_tick;
	logic                    in_en;
	logic                    out_en;
	logic                    in_clr;
	logic                    out_clr;
	logic                    ta_in, ta_out, tb_in, tb_out;
	logic                    ea_in, ea_out, eb_in, eb_out;
	logic                    ca_in, ca_out, cb_in, cb_out;
	logic [`MDR_AW-1:0]      aq_a, aq_b;
	logic [`MDR_BEW-1:0]     bq_a, bq_b;
	logic                    we_a, we_b;
	logic                    acc_a, acc_b;
	mdr_word_type            wq_a, wq_b;
	mdr_word_type            oq_a, oq_b;
	mdr_word_type            raw_a_r, raw_b_r;
	mdr_word_type            mask_a, mask_b;
	logic                    wr_a, wr_b;
	logic                    rd_a, rd_b;
	logic [`MDR_IW-1:0]      ia, ib;
	mdr_word_type            mem [0:`MDR_DEPTH-1];

	// port clocks arrive as sampled levels; rising edges become ticks
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			clka_d_r <= 1'b0;
			clkb_d_r <= 1'b0;
		end
		else
		begin
			clka_d_r <= clk_a;
			clkb_d_r <= clk_b;
		end
	end
	assign tick_a = clk_a && !clka_d_r;
	assign tick_b = clk_b && !clkb_d_r;

	assign io_mode = ctrl_r[`MDR_B_IO];
	assign simple  = ctrl_r[`MDR_B_SIMPLE];
	assign in_sel  = ctrl_r[`MDR_B_INSEL];

	// input/output mode: chosen clock feeds inputs, the other feeds outputs
	assign in_tick  = in_sel ? tick_b : tick_a; // [R03] [R12]
	assign out_tick = in_sel ? tick_a : tick_b;
	assign in_en    = in_sel ? clken_b : clken_a; // [R13]
	assign out_en   = in_sel ? clken_a : clken_b;
	assign in_clr   = in_sel ? clr_b : clr_a;
	assign out_clr  = in_sel ? clr_a : clr_b;

	// independent mode: each port runs wholly on its own clock
	assign ta_in  = io_mode ? in_tick : tick_a; // [R07] [R08] [R11]
	assign ta_out = io_mode ? out_tick : tick_a;
	assign tb_in  = io_mode ? in_tick : tick_b;
	assign tb_out = io_mode ? out_tick : tick_b;
	assign ea_in  = io_mode ? in_en : clken_a; // [R09]
	assign ea_out = io_mode ? out_en : clken_a;
	assign eb_in  = io_mode ? in_en : clken_b;
	assign eb_out = io_mode ? out_en : clken_b;
	assign ca_in  = io_mode ? in_clr : clr_a;
	assign ca_out = io_mode ? out_clr : clr_a;
	assign cb_in  = io_mode ? in_clr : clr_b;
	assign cb_out = io_mode ? out_clr : clr_b;

	mdr_port u_port_a (
		.pclk     (pclk),
		.presetn  (presetn),
		.in_tick  (ta_in),
		.out_tick (ta_out),
		.in_en    (ea_in),
		.out_en   (ea_out),
		.in_clr   (ca_in),
		.out_clr  (ca_out),
		.we_keep  (1'b0),
		.addr     (addr_a),
		.be       (be_a),
		.renwe    (renwe_a),
		.wdata    (wdata_a),
		.raw      (raw_a_r),
		.addr_q   (aq_a),
		.be_q     (bq_a),
		.we_q     (we_a),
		.wdata_q  (wq_a),
		.acc_q    (acc_a),
		.out_q    (oq_a)
	);

	mdr_port u_port_b (
		.pclk     (pclk),
		.presetn  (presetn),
		.in_tick  (tb_in),
		.out_tick (tb_out),
		.in_en    (eb_in),
		.out_en   (eb_out),
		.in_clr   (cb_in),
		.out_clr  (cb_out),
		.we_keep  (simple && io_mode), // [R14]
		.addr     (addr_b),
		.be       (be_b),
		.renwe    (renwe_b),
		.wdata    (wdata_b),
		.raw      (raw_b_r),
		.addr_q   (aq_b),
		.be_q     (bq_b),
		.we_q     (we_b),
		.wdata_q  (wq_b),
		.acc_q    (acc_b),
		.out_q    (oq_b)
	);

	// lane mask: 9-bit lanes, or 8-bit lanes in the low 64 bits
	function automatic mdr_word_type lane_mask(input logic [`MDR_BEW-1:0] be,
		input logic narrow, input logic force_all);
		mdr_word_type m;
		logic [`MDR_BEW-1:0] e;
		m = '0;
		e = force_all ? `MDR_BE_ALL : be; // [R16]
		for (int i = 0; i < `MDR_BEW; i++)
		begin
			if (narrow)
				m[i*`MDR_LANE8 +: `MDR_LANE8] = {`MDR_LANE8{e[i]}}; // [R02]
			else
				m[i*`MDR_LANE9 +: `MDR_LANE9] = {`MDR_LANE9{e[i]}}; // [R01]
		end
		return m;
	endfunction

	assign mask_a = lane_mask(bq_a, ctrl_r[`MDR_B_NARROW], ctrl_r[`MDR_B_BEFORCE]);
	assign mask_b = lane_mask(bq_b, ctrl_r[`MDR_B_NARROW], ctrl_r[`MDR_B_BEFORCE]);
	assign ia     = aq_a[`MDR_IW-1:0];
	assign ib     = aq_b[`MDR_IW-1:0];
	// simple mode: port a writes, port b reads with renwe as read enable
	assign wr_a   = acc_a && we_a; // [R15]
	assign wr_b   = acc_b && we_b && !simple;
	assign rd_a   = acc_a && !we_a;
	assign rd_b   = acc_b && (simple ? we_b : !we_b); // [R11]

	// storage has no reset; port b wins a same-word collision
	always_ff @(posedge pclk)
	begin
		if (wr_a)
			mem[ia] <= (mem[ia] & ~mask_a) | (wq_a & mask_a); // [R01] [R17]
		if (wr_b)
			mem[ib] <= (mem[ib] & ~mask_b) | (wq_b & mask_b); // [R01]
	end

	// raw read word, held until the next read or an output clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			raw_a_r <= '0;
			raw_b_r <= '0;
		end
		else
		begin
			if (ca_out)
				raw_a_r <= '0; // [R10]
			else if (rd_a)
				raw_a_r <= mem[ia];
			if (cb_out)
				raw_b_r <= '0;
			else if (rd_b)
				raw_b_r <= mem[ib];
		end
	end

	// read data: output register or its bypass
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rdata_a <= '0;
			rdata_b <= '0;
		end
		else
		begin
			rdata_a <= ctrl_r[`MDR_B_BYPA] ? raw_a_r : oq_a; // [R04] [R05]
			rdata_b <= ctrl_r[`MDR_B_BYPB] ? raw_b_r : oq_b; // [R04]
		end
	end

	// count of word writes performed
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wcnt_r <= '0;
		else if (wr_a && wr_b)
			wcnt_r <= wcnt_r + `MDR_WCNT_ONE + `MDR_WCNT_ONE;
		else if (wr_a || wr_b)
			wcnt_r <= wcnt_r + `MDR_WCNT_ONE;
	end

	// apb slave: answer in the second access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			apb_r   <= MDR_IDLE;
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end
		else
		begin
			unique case (apb_r)
				MDR_IDLE:
				begin
					pready  <= 1'b0;
					pslverr <= 1'b0;
					prdata  <= '0;
					if (psel && penable)
					begin
						apb_r   <= MDR_ACK;
						pready  <= 1'b1;
						pslverr <= !(paddr == `MDR_CTRL_OFF || paddr == `MDR_STAT_OFF
							|| paddr == `MDR_WCNT_OFF);
						if (!pwrite && paddr == `MDR_CTRL_OFF)
							prdata <= {25'h0000000, ctrl_r};
						else if (!pwrite && paddr == `MDR_STAT_OFF)
							prdata <= {28'h0000000, we_b, acc_b, we_a, acc_a};
						else if (!pwrite && paddr == `MDR_WCNT_OFF)
							prdata <= {16'h0000, wcnt_r};
					end
				end
				MDR_ACK:
				begin
					apb_r   <= MDR_IDLE;
					pready  <= 1'b0;
					pslverr <= 1'b0;
					prdata  <= '0;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_r <= `MDR_CTRL_RST;
		else if (apb_r == MDR_IDLE && psel && penable && pwrite && paddr == `MDR_CTRL_OFF)
			ctrl_r <= pwdata[`MDR_CTRL_W-1:0];
	end

	// checks
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_read_a;
		acc_a && !we_a ##1 1'b1;
	endsequence
	sequence s_read_b_simple;
		simple && acc_b && we_b ##1 1'b1;
	endsequence

	property p_acc_from_tick;
		acc_a |-> $past(ta_in) && $past(ea_in) && !$past(ca_in);
	endproperty
	a_acc_from_tick: assert property (p_acc_from_tick) else $error("port a access without tick"); // [R03]

	property p_hold_no_en;
		ta_in && !ea_in && !ca_in |=> !acc_a && $stable(aq_a) && $stable(wq_a);
	endproperty
	a_hold_no_en: assert property (p_hold_no_en) else $error("disabled port a moved"); // [R18]

	property p_lane_written;
		logic [`MDR_IW-1:0] i;
		mdr_word_type m, d;
		(wr_a && !(wr_b && ib == ia), i = ia, m = mask_a, d = wq_a) |=> ((mem[i] ^ d) & m) == '0;
	endproperty
	a_lane_written: assert property (p_lane_written) else $error("enabled lanes not written"); // [R01]

	property p_lane_kept;
		logic [`MDR_IW-1:0] i;
		mdr_word_type m, o;
		(wr_a && !(wr_b && ib == ia), i = ia, m = mask_a, o = mem[ia]) |=> ((mem[i] ^ o) & ~m) == '0;
	endproperty
	a_lane_kept: assert property (p_lane_kept) else $error("disabled lanes changed"); // [R01]

	property p_narrow_lanes;
		ctrl_r[`MDR_B_NARROW] && !ctrl_r[`MDR_B_BEFORCE] |-> mask_a[71:64] == 8'h00
			&& mask_a[15:8] == {8{bq_a[1]}};
	endproperty
	a_narrow_lanes: assert property (p_narrow_lanes) else $error("8-bit lane mask wrong"); // [R02]

	property p_bypass;
		s_read_a ##0 ctrl_r[`MDR_B_BYPA] && !ca_out |=> rdata_a == $past(raw_a_r);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypassed read data wrong"); // [R04]

	property p_outreg;
		!ctrl_r[`MDR_B_BYPA] |=> rdata_a == $past(oq_a);
	endproperty
	a_outreg: assert property (p_outreg) else $error("registered read data wrong"); // [R04]

	property p_clear;
		ca_in |=> !acc_a && aq_a == '0 && !we_a;
	endproperty
	a_clear: assert property (p_clear) else $error("port a clear ignored"); // [R09]

	property p_keep_rden;
		simple && io_mode && cb_in && !eb_in ##1 simple && io_mode |-> $stable(we_b);
	endproperty
	a_keep_rden: assert property (p_keep_rden) else $error("read enable was cleared"); // [R14]

	property p_sdp_read;
		logic [`MDR_IW-1:0] i;
		(simple && acc_b && we_b && !cb_out && !wr_a, i = ib) ##0 s_read_b_simple |-> raw_b_r == mem[i];
	endproperty
	a_sdp_read: assert property (p_sdp_read) else $error("simple mode read wrong"); // [R11]
endmodule
`default_nettype wire

// File: verif/mdr_user.sv
// user-logic model for one memory port: clock ticks, a held address and port inputs that go stale after the tick
`timescale 1ns/100ps
`default_nettype none
module mdr_user
	import mdr_pkg::*;
(
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         start,
	input  wire logic         we_in,
	input  wire logic [15:0]  addr_in,
	input  wire logic [7:0]   be_in,
	input  wire mdr_word_type wdata_in,
	output logic              clk_o,
	output logic              renwe_o,
	output logic [15:0]       addr_o,
	output logic [7:0]        be_o,
	output mdr_word_type      wdata_o
);
	// clock high for one pclk per request, still otherwise
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			clk_o <= 1'b0;
		else
			clk_o <= start;
	end

	// address held until the next request, other lines go stale after the tick
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			renwe_o <= 1'b0;
			addr_o <= 16'h0000;
			be_o <= 8'h00;
			wdata_o <= 72'h0;
		end
		else if (start)
		begin
			renwe_o <= we_in;
			addr_o <= addr_in;
			be_o <= be_in;
			wdata_o <= wdata_in;
		end
		else if (clk_o)
		begin
			renwe_o <= ~renwe_o;
			be_o <= ~be_o;
			wdata_o <= ~wdata_o;
		end
	end
endmodule
`default_nettype wire

// File: verif/tb.sv
// self-checking bench: apb control and both memory ports
`timescale 1ns/100ps
`default_nettype none
`define CHK(n,e,g) begin checks++; if ((g) !== (e)) begin failures++; $display("wrong value %s exp %h got %h", n, e, g); end end
module tb
	import mdr_pkg::*;
;
	logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0]  paddr;
	logic [31:0]  pwdata, prdata;
	logic         clk_a, clk_b, renwe_a, renwe_b, clr_a, clr_b, lk, lp;
	logic [15:0]  addr_a, addr_b;
	logic [7:0]   be_a, be_b;
	mdr_word_type wdata_a, wdata_b, rdata_a, rdata_b, ex;
	logic         st[2], wi[2], ce[2];
	logic [15:0]  ai[2];
	logic [7:0]   ei[2];
	mdr_word_type di[2];
	logic [32:0]  ax;
	logic [32:0]  qa[$];
	mdr_word_type qx[$];
	int           checks, failures, cyc;

	mdr_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.clk_a(clk_a), .clken_a(ce[0]), .clr_a(clr_a), .addr_a(addr_a), .be_a(be_a), .renwe_a(renwe_a),
		.wdata_a(wdata_a), .rdata_a(rdata_a), .clk_b(clk_b), .clken_b(ce[1]), .clr_b(clr_b),
		.addr_b(addr_b), .be_b(be_b), .renwe_b(renwe_b), .wdata_b(wdata_b), .rdata_b(rdata_b));
	mdr_user u_a (.pclk(pclk), .presetn(presetn), .start(st[0]), .we_in(wi[0]), .addr_in(ai[0]),
		.be_in(ei[0]), .wdata_in(di[0]), .clk_o(clk_a), .renwe_o(renwe_a), .addr_o(addr_a), .be_o(be_a),
		.wdata_o(wdata_a));
	mdr_user u_b (.pclk(pclk), .presetn(presetn), .start(st[1]), .we_in(wi[1]), .addr_in(ai[1]),
		.be_in(ei[1]), .wdata_in(di[1]), .clk_o(clk_b), .renwe_o(renwe_b), .addr_o(addr_b), .be_o(be_b),
		.wdata_o(wdata_b));

	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	task conclude;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	function automatic mdr_word_type rw();
		logic [95:0] t;
		t = {$urandom(), $urandom(), $urandom()};
		return t[71:0];
	endfunction

	// expected word after a lane-masked write
	function automatic mdr_word_type mrg(input mdr_word_type o, input mdr_word_type n, input logic [7:0] e,
		input logic nar);
		mdr_word_type r;
		r = o;
		for (int i = 0; i < 8; i++)
			if (e[i] && nar)
				r[8*i +: 8] = n[8*i +: 8];
			else if (e[i])
				r[9*i +: 9] = n[9*i +: 9];
		return r;
	endfunction

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
		if (!w)
			qa.push_back(e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic op(input logic p, input logic w, input logic [15:0] a, input logic [7:0] e,
		input mdr_word_type d, input logic en);
		st[p] <= 1'b1;
		wi[p] <= w;
		ai[p] <= a;
		ei[p] <= e;
		di[p] <= d;
		ce[p] <= en;
		@(posedge pclk);
		st[p] <= 1'b0;
		repeat (5) @(posedge pclk);
	endtask

	task automatic look(input logic p, input mdr_word_type e);
		qx.push_back(e);
		lp <= p;
		lk <= 1'b1;
		@(posedge pclk);
		lk <= 1'b0;
		@(posedge pclk);
	endtask

	// full write, masked write under ctrl word c, read back
	task automatic trio(input logic [31:0] c, input logic pw, input logic pr, input logic en);
		logic [15:0]  a;
		logic [7:0]   e;
		mdr_word_type w0, w1;
		a = 16'($urandom());
		e = 8'($urandom());
		w0 = rw();
		w1 = rw();
		apb(1'b1, 12'h000, 32'h18, 33'h0);
		op(1'b0, 1'b1, a, 8'hff, w0, 1'b1);
		apb(1'b1, 12'h000, c, 33'h0);
		op(pw, 1'b1, a, e, w1, en);
		op(pr, 1'b0, a, e, ~w1, 1'b1);
		look(pr, en ? mrg(w0, w1, c[6] ? 8'hff : e, c[5]) : w0);
	endtask

	always @(posedge pclk)
	begin
		cyc++;
		if (lk === 1'b1)
		begin
			ex = qx.pop_front();
			`CHK("rdata", ex, lp ? rdata_b : rdata_a)
		end
		if (pready === 1'b1 && pwrite === 1'b0)
		begin
			ax = qa.pop_front();
			`CHK("apb read", ax, {pslverr, prdata})
		end
		if (cyc == 3000)
		begin
			failures++;
			conclude;
		end
	end

	initial
	begin
		mdr_word_type w;
		logic [15:0]  a;
		presetn = 1'b0;
		{psel, penable, pwrite, clr_a, clr_b, lk, lp} = 7'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		st = '{2{1'b0}};
		wi = '{2{1'b0}};
		ce = '{2{1'b0}};
		ai = '{2{16'h0000}};
		ei = '{2{8'h00}};
		di = '{2{72'h0}};
		void'($urandom(43));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h000, 32'h0, 33'h0);
		apb(1'b0, 12'h00c, 32'h0, {1'b1, 32'h0});
		for (int i = 0; i < 4; i++)
			trio(32'h18, i[0], i[1], 1'b1);
		trio(32'h38, 1'b0, 1'b1, 1'b1);
		trio(32'h58, 1'b1, 1'b0, 1'b1);
		trio(32'h18, 1'b0, 1'b0, 1'b0);
		trio(32'h18, 1'b1, 1'b1, 1'b0);
		apb(1'b1, 12'h000, 32'h0, 33'h0);
		a = 16'($urandom());
		w = rw();
		op(1'b0, 1'b1, a, 8'hff, w, 1'b1);
		clr_a <= 1'b1;
		clr_b <= 1'b1;
		@(posedge pclk);
		clr_a <= 1'b0;
		clr_b <= 1'b0;
		// rdata lags the cleared output stage by a cycle
		@(posedge pclk);
		look(1'b0, 72'h0);
		look(1'b1, 72'h0);
		op(1'b0, 1'b0, a, 8'hff, ~w, 1'b1);
		look(1'b0, 72'h0);
		op(1'b0, 1'b0, a, 8'hff, ~w, 1'b1);
		look(1'b0, w);
		// simple dual-port: port b renwe is a read enable, port b never writes
		apb(1'b1, 12'h000, 32'h1a, 33'h0);
		w = rw();
		op(1'b0, 1'b1, a, 8'hff, w, 1'b1);
		op(1'b1, 1'b1, a, 8'hff, ~w, 1'b1);
		look(1'b1, w);
		op(1'b0, 1'b0, a, 8'hff, ~w, 1'b1);
		look(1'b0, w);
		apb(1'b1, 12'h000, 32'h1, 33'h0);
		w = rw();
		op(1'b0, 1'b1, a, 8'hff, w, 1'b1);
		op(1'b0, 1'b0, a, 8'hff, ~w, 1'b1);
		op(1'b1, 1'b0, a, 8'hff, ~w, 1'b1);
		look(1'b0, w);
		clr_b <= 1'b1;
		@(posedge pclk);
		clr_b <= 1'b0;
		@(posedge pclk);
		look(1'b0, 72'h0);
		apb(1'b0, 12'h000, 32'h0, 33'h1);
		// simple io mode: input clear spares the port b read enable
		apb(1'b1, 12'h000, 32'h13, 33'h0);
		op(1'b0, 1'b0, a, 8'hff, ~w, 1'b1);
		ce[0] <= 1'b0;
		clr_a <= 1'b1;
		@(posedge pclk);
		clr_a <= 1'b0;
		apb(1'b0, 12'h004, 32'h0, 33'h8);
		conclude;
	end
endmodule
`default_nettype wire
